/* File: rdac_ctrl.sv */
// Register file and ladder/pin control for the ratiometric reference converter
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rdac_defs.svh"

// Contract
// RQ1: Thirty-two levels from five-bit level code
// RQ2: Converter enable bit turns converter on
// RQ3: Enabled ladder tap index equals level code
// RQ4: Pin output overrides digital driver and detector
// RQ5: Digital pin read returns zero when routed
// RQ6: Low-power bit picks which source disconnects
// RQ7: Disabled, low-power, code 11111 gives positive source
// RQ8: Disabled, no low-power, code 00000 gives negative
// RQ9: Positive source supply, external pin, fixed reference
// RQ10: Level feeds comparator, ADC and pin
// RQ11: Wake from sleep keeps control register
// RQ12: Firmware disables converter before sleep
// RQ13: Unimplemented bits read as zero
// RQ14: Reset disables converter, clears level code
// RQ15: Reset removes level from output pin
// RQ16: Control outputs registered, glitch free
module rdac_ctrl (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pin_digital_in,
  output logic pin_read_value,
  output logic [4:0] ladder_tap,
  output logic ladder_active,
  output logic positive_source_connect,
  output logic negative_source_connect,
  output var rdac_pkg::rdac_src_t positive_ladder_source,
  output logic level_to_comparator,
  output logic level_to_adc,
  output logic converter_output_pin,
  output logic pin_digital_drive_off,
  output logic pin_input_detect_off
);
  import rdac_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic converter_enable_reg;
  logic low_power_source_select_reg;
  logic pin_output_enable_reg;
  logic [1:0] positive_source_select_reg;
  logic [4:0] level_code_reg;
  logic access_done_reg;
  logic [2:0] pin_sync_reg;
  logic pin_level_reg;
  logic wr_ctl;
  logic wr_lvl;
  logic [31:0] rd_next;

  // Bus handshake: every access waits one cycle, then completes
  assign wr_ctl = avs_write && !avs_waitrequest && avs_byteenable[0] && (avs_address == `RDAC_ADDR_CONTROL);
  assign wr_lvl = avs_write && !avs_waitrequest && avs_byteenable[0] && (avs_address == `RDAC_ADDR_LEVEL);

  // ----------------------------------------------------------------
  // Avalon slave timing
  // ----------------------------------------------------------------
  // One wait cycle per access keeps readdata registered and stable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      access_done_reg <= 1'b0;
    end else if ((avs_read || avs_write) && !access_done_reg) begin
      access_done_reg <= 1'b1;
    end else begin
      access_done_reg <= 1'b0;
    end
  end

  // Waitrequest drops exactly one cycle after a request arrives
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !access_done_reg);
    end
  end

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  // Only a bus write or reset changes these; sleep wake has no path in
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      converter_enable_reg <= 1'b0; // [RQ14]
      low_power_source_select_reg <= 1'b0;
      pin_output_enable_reg <= 1'b0; // [RQ15]
      positive_source_select_reg <= `RDAC_PSS_SUPPLY;
    end else if (wr_ctl) begin // [RQ11]
      converter_enable_reg <= avs_writedata[`RDAC_BIT_ENABLE]; // [RQ2]
      low_power_source_select_reg <= avs_writedata[`RDAC_BIT_LOW_POWER];
      pin_output_enable_reg <= avs_writedata[`RDAC_BIT_PIN_OE];
      positive_source_select_reg <= avs_writedata[`RDAC_PSS_HI:`RDAC_PSS_LO]; // [RQ9]
    end
  end

  // Level code register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      level_code_reg <= `RDAC_LEVEL_RESET; // [RQ14]
    end else if (wr_lvl) begin
      level_code_reg <= avs_writedata[`RDAC_LEVEL_HI:`RDAC_LEVEL_LO]; // [RQ1]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unused and unimplemented bits are masked to zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (avs_address == `RDAC_ADDR_CONTROL) begin
      rd_next[7:0] = {converter_enable_reg, low_power_source_select_reg, pin_output_enable_reg, 1'b0,
                      positive_source_select_reg, 2'b00} & `RDAC_CONTROL_MASK; // [RQ13]
    end else if (avs_address == `RDAC_ADDR_LEVEL) begin
      rd_next[7:0] = {3'b000, level_code_reg} & `RDAC_LEVEL_MASK; // [RQ13]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !access_done_reg) begin
      avs_readdata <= rd_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin digital input path
  // ----------------------------------------------------------------
  // Three-stage capture; a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_sync_reg <= 3'b000;
      pin_level_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], pin_digital_in};
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_level_reg <= pin_sync_reg[2];
      end
    end
  end

  // Detector is forced off while the pin carries the analog level
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_read_value <= 1'b0;
    end else begin
      pin_read_value <= pin_output_enable_reg ? 1'b0 : pin_level_reg; // [RQ5]
    end
  end

  // ----------------------------------------------------------------
  // Ladder and pin mux controls (registered to avoid switch glitches)
  // ----------------------------------------------------------------
  // Disabled: low-power bit chooses which end stays; tap follows code
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ladder_tap <= `RDAC_LEVEL_RESET;
      ladder_active <= 1'b0;
      positive_source_connect <= 1'b0;
      negative_source_connect <= 1'b1;
      positive_ladder_source <= RDAC_SRC_SUPPLY;
    end else begin
      ladder_tap <= level_code_reg; // [RQ3] [RQ7] [RQ8] [RQ16]
      ladder_active <= converter_enable_reg; // [RQ2]
      positive_source_connect <= converter_enable_reg || low_power_source_select_reg; // [RQ6] [RQ7]
      negative_source_connect <= converter_enable_reg || !low_power_source_select_reg; // [RQ6] [RQ8]
      positive_ladder_source <= rdac_src_t'(positive_source_select_reg); // [RQ9]
    end
  end

  // Level reaches comparator and ADC whenever out of reset; the pin only on request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      level_to_comparator <= 1'b0;
      level_to_adc <= 1'b0;
      converter_output_pin <= 1'b0;
      pin_digital_drive_off <= 1'b0;
      pin_input_detect_off <= 1'b0;
    end else begin
      level_to_comparator <= 1'b1; // [RQ10]
      level_to_adc <= 1'b1; // [RQ10]
      converter_output_pin <= pin_output_enable_reg; // [RQ4]
      pin_digital_drive_off <= pin_output_enable_reg; // [RQ4]
      pin_input_detect_off <= pin_output_enable_reg; // [RQ4]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_tap_follows;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_lvl |=> ##1 (ladder_tap == $past(avs_writedata[`RDAC_LEVEL_HI:`RDAC_LEVEL_LO], 2));
  endproperty
  a_tap_follows: assert property (p_tap_follows) else $error("ladder tap not equal to code"); // [RQ3]

  property p_lvl_hold;
    @(posedge ref_clk) disable iff (sys_rst) !wr_lvl |=> $stable(level_code_reg);
  endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("level code changed without write"); // [RQ1]

  property p_src_follows;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_ctl |=> ##1 (positive_ladder_source == $past(avs_writedata[`RDAC_PSS_HI:`RDAC_PSS_LO], 2));
  endproperty
  a_src_follows: assert property (p_src_follows) else $error("source select not on ladder"); // [RQ9]

  property p_enabled_both;
    @(posedge ref_clk) disable iff (sys_rst)
      converter_enable_reg |=> (positive_source_connect && negative_source_connect);
  endproperty
  a_enabled_both: assert property (p_enabled_both) else $error("enabled ladder missing an end"); // [RQ3]

  property p_lp_ends;
    @(posedge ref_clk) disable iff (sys_rst)
      (!converter_enable_reg && low_power_source_select_reg) |=> (!negative_source_connect && positive_source_connect);
  endproperty
  a_lp_ends: assert property (p_lp_ends) else $error("low power did not drop negative end"); // [RQ6]

  property p_nlp_ends;
    @(posedge ref_clk) disable iff (sys_rst)
      (!converter_enable_reg && !low_power_source_select_reg) |=> (negative_source_connect && !positive_source_connect);
  endproperty
  a_nlp_ends: assert property (p_nlp_ends) else $error("no low power did not drop positive end"); // [RQ6]

  property p_enable_write;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_ctl && avs_writedata[`RDAC_BIT_ENABLE] |=> ##1 ladder_active;
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write not seen on ladder"); // [RQ2]

  property p_pin_route;
    @(posedge ref_clk) disable iff (sys_rst)
      pin_output_enable_reg |=> (converter_output_pin && pin_digital_drive_off && pin_input_detect_off);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin not routed to converter level"); // [RQ4]

  property p_drive_release;
    @(posedge ref_clk) disable iff (sys_rst)
      !pin_output_enable_reg |=> (!converter_output_pin && !pin_digital_drive_off && !pin_input_detect_off);
  endproperty
  a_drive_release: assert property (p_drive_release) else $error("pin not returned to digital use"); // [RQ15]

  property p_feeds_analog;
    @(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> (level_to_comparator && level_to_adc);
  endproperty
  a_feeds_analog: assert property (p_feeds_analog) else $error("level not fed to comparator and ADC"); // [RQ10]

  property p_pin_reads_zero;
    @(posedge ref_clk) disable iff (sys_rst) pin_output_enable_reg |=> !pin_read_value;
  endproperty
  a_pin_reads_zero: assert property (p_pin_reads_zero) else $error("routed pin read not zero"); // [RQ5]

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (sys_rst)
      !avs_waitrequest && avs_read |-> (avs_readdata[31:8] == 24'h000000)
        && (avs_address != `RDAC_ADDR_CONTROL || (avs_readdata[7:0] & ~`RDAC_CONTROL_MASK) == 8'h00)
        && (avs_address != `RDAC_ADDR_LEVEL || (avs_readdata[7:0] & ~`RDAC_LEVEL_MASK) == 8'h00)
        && (avs_address == `RDAC_ADDR_CONTROL || avs_address == `RDAC_ADDR_LEVEL || avs_readdata[7:0] == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("unimplemented bits read nonzero"); // [RQ13]

  property p_reset_clears;
    @(posedge ref_clk) sys_rst |=> (level_code_reg == `RDAC_LEVEL_RESET && !converter_enable_reg);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear converter"); // [RQ14]

  property p_reset_pin;
    @(posedge ref_clk) sys_rst |=> ##1 !converter_output_pin;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset left level on pin"); // [RQ15]

  property p_ctl_hold;
    @(posedge ref_clk) disable iff (sys_rst) !wr_ctl |=> $stable(converter_enable_reg);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("control changed without write"); // [RQ11]

  property p_wait_once;
    @(posedge ref_clk) disable iff (sys_rst) (avs_read || avs_write) && avs_waitrequest |-> ##1 !avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("request not answered next cycle"); // [RQ16]

  property p_wait_short;
    @(posedge ref_clk) disable iff (sys_rst) !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_short: assert property (p_wait_short) else $error("waitrequest low for more than one cycle"); // [RQ16]

endmodule : rdac_ctrl
`default_nettype wire

/* File: rdac_defs.svh */
// Constants for the ratiometric reference converter control block
`ifndef RDAC_DEFS_SVH
`define RDAC_DEFS_SVH
// Register byte addresses (word aligned)
`define RDAC_ADDR_CONTROL 4'h0
`define RDAC_ADDR_LEVEL 4'h4
// Control register field positions
`define RDAC_BIT_ENABLE 7
`define RDAC_BIT_LOW_POWER 6
`define RDAC_BIT_PIN_OE 5
`define RDAC_PSS_HI 3
`define RDAC_PSS_LO 2
// Level register field
`define RDAC_LEVEL_HI 4
`define RDAC_LEVEL_LO 0
`define RDAC_LEVEL_BITS 5
`define RDAC_LEVEL_STEPS 32
// Reset values and readback masks
`define RDAC_CONTROL_RESET 8'h00
`define RDAC_LEVEL_RESET 5'h00
`define RDAC_CONTROL_MASK 8'hEC
`define RDAC_LEVEL_MASK 8'h1F
`define RDAC_LEVEL_FULL 5'h1F
`define RDAC_LEVEL_ZERO 5'h00
// Positive source select codes
`define RDAC_PSS_SUPPLY 2'h0
`define RDAC_PSS_EXT_PIN 2'h1
`define RDAC_PSS_FIXED_REF 2'h2
`endif

/* File: rdac_pkg.sv */
// Types for the ratiometric reference converter control block
`default_nettype none
package rdac_pkg;
  // Positive ladder source choices
  typedef enum logic [1:0] {
    RDAC_SRC_SUPPLY = 2'h0,
    RDAC_SRC_EXT_PIN = 2'h1,
    RDAC_SRC_FIXED_REF = 2'h2,
    RDAC_SRC_RESERVED = 2'h3
  } rdac_src_t;
endpackage : rdac_pkg
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the ratiometric reference converter control block
`timescale 1ns/1ps
`default_nettype none
`include "rdac_defs.svh"
module tb;
  import rdac_pkg::*;
  logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, pin_digital_in, pin_read_value;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [4:0] ladder_tap;
  logic ladder_active, positive_source_connect, negative_source_connect, level_to_comparator, level_to_adc;
  logic converter_output_pin, pin_digital_drive_off, pin_input_detect_off;
  rdac_src_t positive_ladder_source;
  logic [6:0] st;
  int miscompares, samples_checked, i;

  // ----------------------------------------
  // Design and status bundle
  // ----------------------------------------
  rdac_ctrl dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_digital_in(pin_digital_in),
    .pin_read_value(pin_read_value), .ladder_tap(ladder_tap), .ladder_active(ladder_active),
    .positive_source_connect(positive_source_connect), .negative_source_connect(negative_source_connect),
    .positive_ladder_source(positive_ladder_source), .level_to_comparator(level_to_comparator),
    .level_to_adc(level_to_adc), .converter_output_pin(converter_output_pin),
    .pin_digital_drive_off(pin_digital_drive_off), .pin_input_detect_off(pin_input_detect_off));
  // Packed view of seven single-bit outputs (not the comparator and ADC feeds), compared as one value
  assign st = {ladder_active, positive_source_connect, negative_source_connect, converter_output_pin,
    pin_digital_drive_off, pin_input_detect_off, pin_read_value};

  // Free-running 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    if (n >= 40) begin
      miscompares++;
      wrap_up();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(rd, exp);
  endtask : rdc

  // Outputs lag the stored write by one edge; the pin path adds a 3-flop capture
  task automatic settle;
    repeat (5) @(posedge ref_clk);
  endtask : settle

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    miscompares = 0;
    samples_checked = 0;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    pin_digital_in = 1'b1;
    sys_rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    // Reset state: disabled, code zero, pin not routed
    rdc(`RDAC_ADDR_CONTROL, 32'h00);
    rdc(`RDAC_ADDR_LEVEL, 32'h00);
    settle();
    chk(st, 7'b0010001);
    chk({level_to_comparator, level_to_adc}, 2'b11);
    // All ones written; unimplemented bits must read back clear
    wr(`RDAC_ADDR_CONTROL, 8'hFF);
    rdc(`RDAC_ADDR_CONTROL, 32'hEC);
    wr(`RDAC_ADDR_LEVEL, 8'hFF);
    rdc(`RDAC_ADDR_LEVEL, 32'h1F);
    settle();
    chk(st, 7'b1111110);
    // Every one of the 32 codes reaches the ladder tap
    for (i = 0; i < 32; i++) begin
      wr(`RDAC_ADDR_LEVEL, i[7:0]);
      settle();
      chk(ladder_tap, i[4:0]);
    end
    // Each positive source code, pin released back to digital use
    for (i = 0; i < 4; i++) begin
      wr(`RDAC_ADDR_CONTROL, 8'h80 | (i[7:0] << 2));
      settle();
      chk(positive_ladder_source, i[1:0]);
      chk(st, 7'b1110001);
    end
    // Clamp to positive source at least power
    wr(`RDAC_ADDR_CONTROL, 8'h48);
    wr(`RDAC_ADDR_LEVEL, 8'h1F);
    settle();
    chk(st, 7'b0100001);
    chk(ladder_tap, 5'h1F);
    // Clamp to negative source with low power off
    wr(`RDAC_ADDR_CONTROL, 8'h00);
    wr(`RDAC_ADDR_LEVEL, 8'h00);
    settle();
    chk(st, 7'b0010001);
    chk(ladder_tap, `RDAC_LEVEL_ZERO);
    // Unrouted pin follows its input through the capture stages
    pin_digital_in <= 1'b0;
    settle();
    settle();
    chk(pin_read_value, 1'b0);
    pin_digital_in <= 1'b1;
    // Unmapped address and a write without lane 0 are both ignored
    wr(4'h8, 8'hFF);
    rdc(4'h8, 32'h00);
    bus(1'b1, `RDAC_ADDR_LEVEL, 8'h1F, 4'hE);
    rdc(`RDAC_ADDR_LEVEL, 32'h00);
    // Reset in mid-run while routed and enabled
    wr(`RDAC_ADDR_CONTROL, 8'hA0);
    wr(`RDAC_ADDR_LEVEL, 8'h15);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rdc(`RDAC_ADDR_CONTROL, 32'h00);
    rdc(`RDAC_ADDR_LEVEL, 32'h00);
    settle();
    chk(st, 7'b0010001);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
